// ===== hw/cmeu_host.sv
// Purpose: controller that drives a cascadable error-correction unit and its memory
// Assumes: memory data reaches the unit directly; unit is combinational
// Notes: software orders read, full write, partial write or zero-fill cycles
//
// Added by the designer: strobed register access and the register offsets.
`default_nettype none
module cmeu_host #(
  parameter int MEM_AW = 16,
  parameter logic [3:0] STB_N = cmeu_pkg::STB_CYCLES,
  parameter logic [3:0] SETTLE_N = cmeu_pkg::SETTLE_CYCLES,
  parameter logic [3:0] WR_N = cmeu_pkg::WR_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [cmeu_pkg::REG_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic [MEM_AW-1:0] mem_addr,
  output logic mem_read,
  output logic mem_write,
  output logic read_not_write,
  output logic strobe,
  output logic [1:0] byte_mask,
  output logic write_zeros_n,
  output logic correct_enable,
  output logic [15:0] wdi_out,
  output logic [1:0] wdi_oe_n,
  input wire logic [15:0] do_in,
  input wire logic error_flag,
  input wire logic correctable_flag,
  input wire logic [7:0] syndrome_in,
  output logic strap_master_select,
  output logic strap_multi_chip_select,
  output logic [1:0] strap_slave_index,
  input wire logic [cmeu_pkg::MAX_SLAVES*cmeu_pkg::PP_W-1:0] slave_partial_parity_out,
  output logic [cmeu_pkg::PP_W-1:0] partial_parity_in
);
  cmeu_pp_if pp_bus ();

  // ---- register file group
  logic [5:0] ctrl, next_ctrl;
  logic [MEM_AW-1:0] addr_reg, next_addr_reg;
  logic [17:0] wdata_reg, next_wdata_reg;
  logic [cmeu_pkg::STRAP_W-1:0] strap, next_strap;
  logic [31:0] next_reg_rdata;
  // ---- sequencer group
  cmeu_pkg::cmeu_state_t state, next_state;
  cmeu_pkg::cmeu_op_t op, next_op;
  logic [3:0] cnt, next_cnt;
  logic [6:0] status, next_status;
  logic [15:0] rdata_cap, next_rdata_cap;
  logic [7:0] synd_cap, next_synd_cap;
  logic [15:0] errcnt, next_errcnt;
  logic next_mem_read, next_mem_write, next_rnw, next_strobe, next_wzn;
  logic [1:0] next_bm, next_oe_n;
  logic [15:0] next_wdi;
  logic go;

  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    return a == off;
  endfunction

  assign go = reg_write && hit(reg_addr, cmeu_pkg::REG_CTRL) && reg_wdata[cmeu_pkg::CTRL_GO];

  // software-visible configuration and one-cycle-late read data
  always_comb begin
    next_ctrl = ctrl;
    next_addr_reg = addr_reg;
    next_wdata_reg = wdata_reg;
    next_strap = strap;
    next_reg_rdata = '0;
    if (reg_write && state == cmeu_pkg::S_IDLE) begin
      // config is frozen mid-cycle so pins stay coherent
      if (hit(reg_addr, cmeu_pkg::REG_CTRL)) next_ctrl = reg_wdata[5:0];
      if (hit(reg_addr, cmeu_pkg::REG_ADDR)) next_addr_reg = reg_wdata[MEM_AW-1:0];
      if (hit(reg_addr, cmeu_pkg::REG_WDATA)) next_wdata_reg = reg_wdata[17:0];
      if (hit(reg_addr, cmeu_pkg::REG_STRAP)) next_strap = reg_wdata[cmeu_pkg::STRAP_W-1:0];
    end
    if (reg_read) begin
      unique case (reg_addr)
        cmeu_pkg::REG_CTRL: next_reg_rdata = {26'h0, ctrl[5:1], 1'b0};
        cmeu_pkg::REG_ADDR: next_reg_rdata = 32'(addr_reg);
        cmeu_pkg::REG_WDATA: next_reg_rdata = {14'h0, wdata_reg};
        cmeu_pkg::REG_STATUS: next_reg_rdata = {25'h0, status};
        cmeu_pkg::REG_RDATA: next_reg_rdata = {16'h0, rdata_cap};
        cmeu_pkg::REG_SYND: next_reg_rdata = {24'h0, synd_cap};
        cmeu_pkg::REG_ERRCNT: next_reg_rdata = {16'h0, errcnt};
        cmeu_pkg::REG_STRAP: next_reg_rdata = {25'h0, strap};
        default: next_reg_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl <= cmeu_pkg::CTRL_RESET;
      addr_reg <= '0;
      wdata_reg <= '0;
      strap <= cmeu_pkg::STRAP_RESET;
      reg_rdata <= '0;
    end else begin
      ctrl <= {next_ctrl[5:1], 1'b0};
      addr_reg <= next_addr_reg;
      wdata_reg <= next_wdata_reg;
      strap <= next_strap;
      reg_rdata <= next_reg_rdata;
    end
  end

  // strap pins follow the strap register
  always_ff @(posedge clk) begin
    if (reset) begin
      strap_master_select <= 1'b1;
      strap_multi_chip_select <= 1'b0;
      strap_slave_index <= 2'h0;
    end else begin
      strap_master_select <= strap[0];
      strap_multi_chip_select <= strap[1];
      strap_slave_index <= strap[3:2];
    end
  end

  // cycle sequencer: pins, captures and status
  always_comb begin
    next_state = state;
    next_op = op;
    next_cnt = cnt;
    next_status = status;
    next_rdata_cap = rdata_cap;
    next_synd_cap = synd_cap;
    next_errcnt = errcnt;
    next_mem_read = mem_read;
    next_mem_write = mem_write;
    next_rnw = read_not_write;
    next_strobe = strobe;
    next_wzn = write_zeros_n;
    next_bm = byte_mask;
    next_oe_n = wdi_oe_n;
    next_wdi = wdi_out;
    // done clears by writing one; a completion in the same cycle wins
    if (reg_write && hit(reg_addr, cmeu_pkg::REG_STATUS) && reg_wdata[cmeu_pkg::ST_DONE]) begin
      next_status[cmeu_pkg::ST_DONE] = 1'b0;
    end
    unique case (state)
      cmeu_pkg::S_IDLE: begin
        if (go) begin
          next_op = cmeu_pkg::cmeu_op_t'(reg_wdata[cmeu_pkg::CTRL_OP +: 2]);
          next_status = '0;
          next_status[cmeu_pkg::ST_BUSY] = 1'b1;
          unique case (cmeu_pkg::cmeu_op_t'(reg_wdata[cmeu_pkg::CTRL_OP +: 2]))
            cmeu_pkg::OP_READ, cmeu_pkg::OP_PARTIAL: begin
              next_rnw = 1'b1;
              next_bm = reg_wdata[cmeu_pkg::CTRL_NARROW] ? 2'b01 : 2'b11;
              next_strobe = 1'b1;
              next_mem_read = 1'b1;
              next_cnt = STB_N - 4'h1;
              next_state = cmeu_pkg::S_RD_STROBE;
            end
            cmeu_pkg::OP_WRITE: begin
              next_rnw = 1'b0;
              next_bm = 2'b00;
              next_oe_n = 2'b00;
              next_wdi = reg_wdata[cmeu_pkg::CTRL_NARROW] ? {8'h00, wdata_reg[7:0]}
                                                          : wdata_reg[15:0];
              next_state = cmeu_pkg::S_WR_SETUP;
            end
            cmeu_pkg::OP_ZERO: begin
              next_wzn = 1'b0;
              next_state = cmeu_pkg::S_WR_SETUP;
            end
          endcase
        end
      end
      cmeu_pkg::S_RD_STROBE: begin
        if (cnt == 4'h0) begin
          next_strobe = 1'b0; // falling strobe latches data and check bits
          next_mem_read = 1'b0;
          next_cnt = SETTLE_N - 4'h1;
          next_state = cmeu_pkg::S_RD_SETTLE;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      cmeu_pkg::S_RD_SETTLE: begin
        // settle spans the unit's combinational path and the parity register
        if (cnt == 4'h0) next_state = cmeu_pkg::S_EVAL;
        else next_cnt = cnt - 4'h1;
      end
      cmeu_pkg::S_EVAL: begin
        next_rdata_cap = do_in;
        next_synd_cap = syndrome_in;
        next_status[cmeu_pkg::ST_ERR] = error_flag;
        next_status[cmeu_pkg::ST_CORR] = error_flag && correctable_flag;
        next_status[cmeu_pkg::ST_UNCORR] = error_flag && !correctable_flag;
        if (error_flag && errcnt != cmeu_pkg::ERRCNT_MAX) next_errcnt = errcnt + 16'h1;
        next_state = cmeu_pkg::S_DONE;
        if (op == cmeu_pkg::OP_READ) begin
          if (ctrl[cmeu_pkg::CTRL_SCRUB] && !ctrl[cmeu_pkg::CTRL_CHECK_ONLY]
              && error_flag && correctable_flag) begin
            next_rnw = 1'b0; // unit latches syndrome, drives fixed word
            next_status[cmeu_pkg::ST_SCRUBBED] = 1'b1;
            next_state = cmeu_pkg::S_WR_SETUP;
          end
        end else if (error_flag && !correctable_flag) begin
          // writing back a bad word would hide the fault behind fresh check bits
          next_status[cmeu_pkg::ST_ABORTED] = 1'b1;
        end else begin
          next_rnw = 1'b0;
          next_bm = ~wdata_reg[cmeu_pkg::WDATA_REPL +: 2];
          next_oe_n = ~wdata_reg[cmeu_pkg::WDATA_REPL +: 2];
          next_wdi = wdata_reg[15:0];
          if (ctrl[cmeu_pkg::CTRL_NARROW]) begin
            next_bm[1] = 1'b0;
            next_oe_n[1] = 1'b0;
            next_wdi[15:8] = 8'h00;
          end
          next_state = cmeu_pkg::S_WR_SETUP;
        end
      end
      cmeu_pkg::S_WR_SETUP: begin
        next_mem_write = 1'b1;
        next_cnt = WR_N - 4'h1;
        next_state = cmeu_pkg::S_WR_PULSE;
      end
      cmeu_pkg::S_WR_PULSE: begin
        if (cnt == 4'h0) begin
          next_mem_write = 1'b0;
          next_state = cmeu_pkg::S_DONE;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      cmeu_pkg::S_DONE: begin
        // park: read mode, unit outputs tristated, host bus released
        next_rnw = 1'b1;
        next_bm = 2'b00;
        next_oe_n = 2'b11;
        next_wzn = 1'b1;
        next_wdi = 16'h0000;
        next_status[cmeu_pkg::ST_BUSY] = 1'b0;
        next_status[cmeu_pkg::ST_DONE] = 1'b1;
        next_state = cmeu_pkg::S_IDLE;
      end
      default: next_state = cmeu_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= cmeu_pkg::S_IDLE;
      op <= cmeu_pkg::OP_READ;
      cnt <= 4'h0;
      status <= '0;
      rdata_cap <= '0;
      synd_cap <= '0;
      errcnt <= '0;
      mem_addr <= '0;
      mem_read <= 1'b0;
      mem_write <= 1'b0;
      read_not_write <= 1'b1;
      strobe <= 1'b0;
      write_zeros_n <= 1'b1;
      correct_enable <= 1'b0;
      byte_mask <= 2'b00;
      wdi_oe_n <= 2'b11;
      wdi_out <= '0;
    end else begin
      state <= next_state;
      op <= next_op;
      cnt <= next_cnt;
      status <= next_status;
      rdata_cap <= next_rdata_cap;
      synd_cap <= next_synd_cap;
      errcnt <= next_errcnt;
      mem_addr <= addr_reg;
      mem_read <= next_mem_read;
      mem_write <= next_mem_write;
      read_not_write <= next_rnw;
      strobe <= next_strobe;
      write_zeros_n <= next_wzn;
      correct_enable <= ctrl[cmeu_pkg::CTRL_CHECK_ONLY];
      byte_mask <= next_bm;
      wdi_oe_n <= next_oe_n;
      wdi_out <= next_wdi;
    end
  end

  // cascade parity combiner feeds the master's partial parity inputs
  assign pp_bus.slave_ppo = slave_partial_parity_out;
  assign pp_bus.slave_count = strap[6:4];

  cmeu_ppx u_ppx (
    .clk(clk),
    .reset(reset),
    .pp(pp_bus.comb_unit)
  );

  assign partial_parity_in = pp_bus.combined;
endmodule
`default_nettype wire

// ===== hw/cmeu_pkg.sv
// Purpose: shared constants and types for the memory error-correction controller
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes: offsets are byte addresses on the plain register port
`default_nettype none
package cmeu_pkg;
  // register port
  localparam int REG_AW = 5;
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_ADDR = 5'h04;
  localparam logic [4:0] REG_WDATA = 5'h08;
  localparam logic [4:0] REG_STATUS = 5'h0c;
  localparam logic [4:0] REG_RDATA = 5'h10;
  localparam logic [4:0] REG_SYND = 5'h14;
  localparam logic [4:0] REG_ERRCNT = 5'h18;
  localparam logic [4:0] REG_STRAP = 5'h1c;
  // control fields
  localparam int CTRL_GO = 0;
  localparam int CTRL_OP = 1;
  localparam int CTRL_SCRUB = 3;
  localparam int CTRL_CHECK_ONLY = 4;
  localparam int CTRL_NARROW = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  // write data register: data in 15:0, replace-byte enables in 17:16
  localparam int WDATA_REPL = 16;
  // status fields
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ERR = 2;
  localparam int ST_CORR = 3;
  localparam int ST_UNCORR = 4;
  localparam int ST_SCRUBBED = 5;
  localparam int ST_ABORTED = 6;
  // strap fields: master, multi, slave index 3:2, slave count 6:4
  localparam int STRAP_W = 7;
  localparam logic [6:0] STRAP_RESET = 7'h01;
  // partial parity cascade
  localparam int PP_W = 8;
  localparam int MAX_SLAVES = 4;
  // cycle counts and error counter limit
  localparam logic [3:0] STB_CYCLES = 4'h2;
  localparam logic [3:0] SETTLE_CYCLES = 4'h3;
  localparam logic [3:0] WR_CYCLES = 4'h2;
  localparam logic [15:0] ERRCNT_MAX = 16'hffff;

  typedef enum logic [1:0] {
    OP_READ = 2'b00,
    OP_WRITE = 2'b01,
    OP_PARTIAL = 2'b10,
    OP_ZERO = 2'b11
  } cmeu_op_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RD_STROBE = 3'b001,
    S_RD_SETTLE = 3'b010,
    S_EVAL = 3'b011,
    S_WR_SETUP = 3'b100,
    S_WR_PULSE = 3'b101,
    S_DONE = 3'b110
  } cmeu_state_t;
endpackage
`default_nettype wire

// ===== hw/cmeu_pp_if.sv
// Purpose: carries slave partial parity into the cascade combiner and back
// Assumes: up to four slaves, eight parity bits each
// Notes: no clocking block; the combiner registers its result
`default_nettype none
interface cmeu_pp_if;
  logic [cmeu_pkg::MAX_SLAVES*cmeu_pkg::PP_W-1:0] slave_ppo;
  logic [2:0] slave_count;
  logic [cmeu_pkg::PP_W-1:0] combined;
  modport ctl (output slave_ppo, output slave_count, input combined);
  modport comb_unit (input slave_ppo, input slave_count, output combined);
endinterface
`default_nettype wire

// ===== hw/cmeu_ppx.sv
// Purpose: folds the partial parity of the active slaves into one word for the master
// Assumes: slave outputs are synchronous to clk
// Notes: one register stage; adds a cycle the sequencer settle count covers
`default_nettype none
module cmeu_ppx (
  input wire logic clk,
  input wire logic reset,
  cmeu_pp_if.comb_unit pp
);
  logic [cmeu_pkg::PP_W-1:0] combined;
  logic [cmeu_pkg::PP_W-1:0] next_combined;

  // xor only the slaves that exist; absent ones must not disturb parity
  always_comb begin
    next_combined = '0;
    for (int i = 0; i < cmeu_pkg::MAX_SLAVES; i++) begin
      if (i < int'(pp.slave_count)) begin
        next_combined = next_combined ^ pp.slave_ppo[i*cmeu_pkg::PP_W +: cmeu_pkg::PP_W];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      combined <= '0;
    end else begin
      combined <= next_combined;
    end
  end

  assign pp.combined = combined;
endmodule
`default_nettype wire

// ===== dv/cmeu_host_properties.sv
// Purpose: timing checks on the unit-side pins of the ecc controller
// Assumes: cycle counts handed on from the controller by bind
// Notes: run-length counters let the pulse lengths follow the parameters
`default_nettype none
module cmeu_host_properties #(
  parameter logic [3:0] STB_N = cmeu_pkg::STB_CYCLES,
  parameter logic [3:0] WR_N = cmeu_pkg::WR_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic mem_read,
  input wire logic mem_write,
  input wire logic read_not_write,
  input wire logic strobe,
  input wire logic [1:0] byte_mask,
  input wire logic write_zeros_n,
  input wire logic [1:0] wdi_oe_n
);
  logic [3:0] stb_len, next_stb_len, wr_len, next_wr_len;
  // pulse run lengths, cleared whenever the pulse is low
  always_comb begin
    next_stb_len = strobe ? stb_len + 4'h1 : 4'h0;
    next_wr_len = mem_write ? wr_len + 4'h1 : 4'h0;
  end
  always_ff @(posedge clk) begin
    stb_len <= reset ? 4'h0 : next_stb_len;
    wr_len <= reset ? 4'h0 : next_wr_len;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // read phase: memory enabled, unit in read, low byte shown
  sequence read_open;
    strobe && mem_read && read_not_write && byte_mask[0];
  endsequence
  // write follows soon after the syndrome latch
  sequence write_follows;
    !strobe ##[1:4] mem_write;
  endsequence
  strobe_len_a: assert property ($fell(strobe) |-> stb_len == STB_N)
    else $error("strobe pulse length wrong");
  read_open_a: assert property ($rose(strobe) |-> read_open)
    else $error("strobe without read setup");
  write_len_a: assert property ($fell(mem_write) |-> wr_len == WR_N)
    else $error("write pulse length wrong");
  no_contention_a: assert property ((byte_mask & ~wdi_oe_n) == 2'b00)
    else $error("host and unit drive one byte");
  zero_fill_a: assert property (!write_zeros_n |-> wdi_oe_n == 2'b11)
    else $error("host drives during zero fill");
  write_phase_a: assert property (mem_write |-> !read_not_write || !write_zeros_n)
    else $error("memory write outside write phase");
  syndrome_latch_a: assert property ($fell(read_not_write) |-> write_follows)
    else $error("write phase without a write");
  mem_exclusive_a: assert property (!(mem_read && mem_write))
    else $error("memory read and write together");
endmodule
bind cmeu_host cmeu_host_properties #(.STB_N(STB_N), .WR_N(WR_N)) i_props (
  .clk(clk), .reset(reset), .mem_read(mem_read), .mem_write(mem_write),
  .read_not_write(read_not_write), .strobe(strobe), .byte_mask(byte_mask),
  .write_zeros_n(write_zeros_n), .wdi_oe_n(wdi_oe_n)
);
`default_nettype wire

// ===== dv/cmeu_unit_model.sv
// Purpose: behavioural error-correction unit with a sixteen-word memory
// Assumes: single 16-bit unit, six check bits
// Notes: planted flips, or an all-zero never-written word, decide the error class; the check table is arbitrary
`default_nettype none
module cmeu_unit_model (
  input wire logic clk,
  input wire logic [15:0] mem_addr,
  input wire logic mem_write,
  input wire logic read_not_write,
  input wire logic strobe,
  input wire logic [1:0] byte_mask,
  input wire logic write_zeros_n,
  input wire logic correct_enable,
  input wire logic [15:0] wdi_out,
  input wire logic [1:0] wdi_oe_n,
  output logic [15:0] do_in,
  output logic error_flag,
  output logic correctable_flag,
  output logic [7:0] syndrome_in
);
  logic [15:0] mem_d [16];
  logic [5:0] mem_c [16];
  logic [15:0] flip [16];
  logic [15:0] raw = 16'h0, good = 16'h0, out_d, wv;
  logic [3:0] ix;
  int nflip = 0;
  logic blank = 1'b0;
  // check table of our own; the two low bits inverted
  function automatic logic [5:0] gen(input logic [15:0] d);
    return {^(d & 16'hff00), ^(d & 16'hf0f0), ^(d & 16'hcccc), ^(d & 16'haaaa),
      ~^(d & 16'h3333), ~^(d & 16'h5555)};
  endfunction
  task automatic corrupt(input int a, input logic [15:0] m);
    flip[a] = m;
  endtask
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem_d[i] = 16'h0;
      mem_c[i] = 6'h0;
      flip[i] = 16'h0;
    end
  end
  assign ix = mem_addr[3:0];
  assign wv = write_zeros_n ? do_in : 16'h0;
  // strobe admits the word; latches hold through the write phase
  always @(posedge clk) begin
    if (strobe && read_not_write) begin
      raw <= mem_d[ix] ^ flip[ix];
      good <= mem_d[ix];
      nflip <= $countones(flip[ix]);
      blank <= mem_d[ix] == 16'h0 && mem_c[ix] == 6'h0;
    end
    if (mem_write) begin
      mem_d[ix] <= wv;
      mem_c[ix] <= gen(wv);
      flip[ix] <= 16'h0;
    end
  end
  // flags and word follow the latched read with no clock
  always_comb begin
    error_flag = blank || nflip != 0;
    correctable_flag = !blank && nflip == 1;
    syndrome_in = blank ? 8'hff : {2'b00, gen(raw) ^ gen(good)};
    out_d = (correctable_flag && !correct_enable) ? good : raw;
  end
  // per byte: zeros, unit output, host data, or a released bus shown inverted
  always_comb begin
    for (int b = 0; b < 2; b++) begin
      if (!write_zeros_n) do_in[8*b+:8] = 8'h00;
      else if (byte_mask[b]) do_in[8*b+:8] = out_d[8*b+:8];
      else if (!wdi_oe_n[b]) do_in[8*b+:8] = wdi_out[8*b+:8];
      else do_in[8*b+:8] = ~out_d[8*b+:8];
    end
  end
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// Purpose: register-level test of the ecc controller against the unit model
// Assumes: default cycle counts
// Notes: errors are planted in the model memory before reads
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, reg_write, reg_read, mem_read, mem_write, read_not_write, strobe;
  logic write_zeros_n, correct_enable, error_flag, correctable_flag;
  logic strap_master_select, strap_multi_chip_select;
  logic [4:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v, slave_pp;
  logic [15:0] mem_addr, wdi_out, do_in;
  logic [1:0] byte_mask, wdi_oe_n, strap_slave_index;
  logic [7:0] syndrome_in, partial_parity_in, pp_exp;
  int num_errors = 0;
  int n_compared = 0;
  cmeu_host i_dut (.clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .mem_addr, .mem_read, .mem_write, .read_not_write, .strobe, .byte_mask, .write_zeros_n,
    .correct_enable, .wdi_out, .wdi_oe_n, .do_in, .error_flag, .correctable_flag,
    .syndrome_in, .strap_master_select, .strap_multi_chip_select, .strap_slave_index,
    .slave_partial_parity_out(slave_pp), .partial_parity_in);
  cmeu_unit_model i_unit (.clk, .mem_addr, .mem_write, .read_not_write, .strobe,
    .byte_mask, .write_zeros_n, .correct_enable, .wdi_out, .wdi_oe_n, .do_in,
    .error_flag, .correctable_flag, .syndrome_in);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // one strobe cycle, then a gap so strobes never reassign in one step
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [4:0] a);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [31:0] exp, input string name);
    rd(a);
    chk(name, v, exp);
  endtask
  // start an operation and poll status, bounded; v ends as the status word
  task automatic run(input logic [3:0] a, input logic [31:0] wd, input logic [7:0] ctl);
    int i;
    wr(cmeu_pkg::REG_ADDR, {28'h0, a});
    wr(cmeu_pkg::REG_WDATA, wd);
    wr(cmeu_pkg::REG_CTRL, {24'h0, ctl});
    for (i = 0; i < 40; i++) begin
      rd(cmeu_pkg::REG_STATUS);
      if (v[cmeu_pkg::ST_DONE] === 1'b1) break;
    end
    if (i == 40) begin
      num_errors++;
      end_of_test();
    end
  endtask
  task automatic rop(input logic [3:0] a, input logic [7:0] ctl, input logic [31:0] st,
    input logic [31:0] d);
    run(a, 32'h0, ctl);
    chk("status", v, st);
    rdchk(cmeu_pkg::REG_RDATA, d, "rdata");
  endtask
  // main sequence: reset, registers, each operation kind, cascade straps
  initial begin
    reset = 1'b1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 32'h0;
    slave_pp = 32'h0f335581;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rdchk(cmeu_pkg::REG_STRAP, 32'h1, "strap");
    rdchk(cmeu_pkg::REG_STATUS, 32'h0, "status");
    rdchk(5'h02, 32'h0, "unmapped");
    run(4'h1, 32'ha5c3, 8'h03);
    rop(4'h1, 8'h01, 32'h02, 32'ha5c3);
    i_unit.corrupt(1, 16'h0010);
    rop(4'h1, 8'h01, 32'h0e, 32'ha5c3);
    rop(4'h1, 8'h11, 32'h0e, 32'ha5d3);
    rop(4'h1, 8'h09, 32'h2e, 32'ha5c3);
    rop(4'h1, 8'h01, 32'h02, 32'ha5c3);
    i_unit.corrupt(1, 16'h0200);
    run(4'h1, 32'h10077, 8'h05);
    rop(4'h1, 8'h01, 32'h02, 32'ha577);
    i_unit.corrupt(1, 16'h0101);
    rop(4'h1, 8'h01, 32'h16, 32'ha476);
    run(4'h1, 32'h100ff, 8'h05);
    chk("aborted", v & 32'h42, 32'h42);
    rop(4'h1, 8'h01, 32'h16, 32'ha476);
    run(4'h2, 32'hffff, 8'h07);
    rop(4'h2, 8'h01, 32'h02, 32'h0);
    rop(4'h3, 8'h01, 32'h16, 32'h0);
    rdchk(cmeu_pkg::REG_SYND, 32'hff, "synd");
    // narrow mode: upper byte must reach memory as zero
    run(4'h4, 32'h1234, 8'h23);
    rop(4'h4, 8'h01, 32'h02, 32'h34);
    run(4'h4, 32'h0, 8'h21);
    chk("narrow_status", v, 32'h02);
    rd(cmeu_pkg::REG_RDATA);
    chk("narrow_rdata", v & 32'hff, 32'h34);
    rdchk(cmeu_pkg::REG_SYND, 32'h0, "synd_clean");
    rdchk(cmeu_pkg::REG_CTRL, 32'h20, "ctrl");
    rdchk(cmeu_pkg::REG_ERRCNT, 32'h8, "errcnt");
    wr(cmeu_pkg::REG_STATUS, 32'h2);
    rdchk(cmeu_pkg::REG_STATUS, 32'h0, "status_clear");
    for (int n = 0; n <= 4; n++) begin
      wr(cmeu_pkg::REG_STRAP, 32'h3 | (n << 4) | ((n & 3) << 2));
      pp_exp = 8'h0;
      for (int s = 0; s < n; s++) pp_exp ^= slave_pp[8*s+:8];
      repeat (2) @(posedge clk);
      chk("pp", {24'h0, partial_parity_in}, {24'h0, pp_exp});
      chk("master", {31'h0, strap_master_select}, 32'h1);
      chk("index", {30'h0, strap_slave_index}, n & 3);
      chk("multi", {31'h0, strap_multi_chip_select}, 32'h1);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
